/* rtl/cssc_defines.svh */
`ifndef CSSC_DEFINES_SVH
`define CSSC_DEFINES_SVH

// ****************************************************************
// Fuse reset values (shipped setting)
// ****************************************************************
`define CSSC_CLOCK_SOURCE_SELECT_FUSES_RESET 4'h1
`define CSSC_SUT_RESET 2'h2
`define CSSC_AMP_RESET 1'h1

// ****************************************************************
// Clock-select code boundaries
// ****************************************************************
`define CSSC_CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN 4'ha
`define CSSC_CLOCK_SOURCE_SELECT_FUSES_LFXTAL 4'h9
`define CSSC_CLOCK_SOURCE_SELECT_FUSES_EXTRC_MIN 4'h5
`define CSSC_CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN 4'h1
`define CSSC_CLOCK_SOURCE_SELECT_FUSES_EXTCLK 4'h0

// ****************************************************************
// Start-up counts in cycles of the selected source
// ****************************************************************
`define CSSC_CK_6 17'h00006
`define CSSC_CK_18 17'h00012
`define CSSC_CK_258 17'h00102
`define CSSC_CK_1K 17'h00400
`define CSSC_CK_16K 17'h04000
`define CSSC_CK_32K 17'h08000

// ****************************************************************
// Reset delay in watchdog oscillator cycles
// ****************************************************************
`define CSSC_WD_SHORT 17'h01000
`define CSSC_WD_LONG 17'h10000

`endif

/* rtl/cssc_pkg.sv */
package cssc_pkg;

   // ****************************************************************
   // Types shared by the clock control files
   // ****************************************************************
   typedef enum logic [2:0] {
      SRC_EXT_CLOCK,
      SRC_INT_RC,
      SRC_EXT_RC,
      SRC_LF_XTAL,
      SRC_XTAL
   } cssc_source_t;

   typedef enum logic [1:0] {
      RD_NONE,
      RD_SHORT,
      RD_LONG
   } cssc_rdelay_t;

   typedef enum logic [2:0] {
      ST_LOAD,
      ST_RESET_DELAY,
      ST_CLOCK_START,
      ST_RUN,
      ST_SLEEP
   } cssc_state_t;

   // Fuse bits as read: 1 unprogrammed, 0 programmed
   typedef struct packed {
      logic [3:0] clockSourceSelectFuses;
      logic [1:0] startupTimeFuses;
      logic amplifierSwingOption;
   } cssc_fuses_t;

   // Stop requests from the sleep controller, 1 stops a domain
   typedef struct packed {
      logic core;
      logic periph;
      logic adc;
   } cssc_gate_req_t;

   // Running state of each gated domain
   typedef struct packed {
      logic core;
      logic periph;
      logic flash;
      logic adc;
   } cssc_domain_en_t;

   // Decoded start-up setting
   typedef struct packed {
      logic [16:0] ckCycles;
      cssc_rdelay_t resetDelay;
   } cssc_startup_t;

endpackage

/* rtl/cssc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module cssc_pin_sync (
   input wire logic clock,
   input wire logic rstN,
   input wire logic pinIn,
   output logic level,
   output logic rise
);

   // ****************************************************************
   // Three-stage synchroniser with agreement filter
   // ****************************************************************
   logic s1_ff; // Metastable stage, read only by s2_ff
   logic s2_ff; // Second stage
   logic s3_ff; // Third stage

   // Shift chain
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         s1_ff <= 1'h0;
         s2_ff <= 1'h0;
         s3_ff <= 1'h0;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Level follows only when two stages agree, so one bad sample is ignored
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         level <= 1'h0;
         rise <= 1'h0;
      end else begin
         rise <= 1'h0;
         if (s2_ff == s3_ff) begin
            level <= s3_ff;
            rise <= s3_ff & ~level;
         end
      end
   end

endmodule

`default_nettype wire

/* rtl/cssc_clock_gate.sv */
`timescale 1ns/1ps
`default_nettype none

module cssc_clock_gate (
   input wire logic clock,
   input wire logic rstN,
   input wire logic enable,
   output logic gatedClock
);

   // ****************************************************************
   // Glitch-free gate
   // ****************************************************************
   logic enLow_ff; // Enable taken while the clock is low

   // Sample on the falling edge so the AND never opens mid-pulse
   always_ff @(negedge clock or negedge rstN) begin
      if (!rstN) begin
         enLow_ff <= 1'h0;
      end else begin
         enLow_ff <= enable;
      end
   end

   // Gated clock
   assign gatedClock = clock & enLow_ff;

endmodule

`default_nettype wire

/* rtl/clock_source_startup_control.sv */
// Overview of operation
// - Stopped core clock holds all core activity
// - Peripheral clock feeds timers; some interrupts unclocked
// - Two-wire address match works without clock
// - Flash clock gated together with core clock
// - Async timer clock straight from crystal
// - Converter clock runs while core stopped by gate request in run state; deep sleep stops it too
// - Decode clock-select fuses into five sources
// - Fuse bit one unprogrammed, zero programmed
// - Wake-up waits selected clock start-up count
// - Reset adds delay timed by watchdog oscillator
// - Reset delay 4096 or 65536 watchdog cycles
// - Shipped fuses: select 0001, start-up 10
// - Crystal mode and amplifier swing from fuses
// - Crystal start-up table, low select bit zero
// - Crystal start-up table, low select bit one
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defines.svh"

module clock_source_startup_control
   import cssc_pkg::*;
#(
   parameter logic [16:0] CK_16K_CYCLES = `CSSC_CK_16K,
   parameter logic [16:0] CK_32K_CYCLES = `CSSC_CK_32K,
   parameter logic [16:0] WD_LONG_CYCLES = `CSSC_WD_LONG
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire cssc_fuses_t fuseIn,
   input wire logic watchdogOscPin,
   input wire logic asyncCrystalClock,
   input wire cssc_gate_req_t gateReq,
   input wire logic deepSleepReq,
   input wire logic wakeEvent,
   input wire logic extIntPin,
   input wire logic [6:0] twiRxAddr,
   input wire logic [6:0] twiOwnAddr,
   input wire logic twiAddrValid,
   output logic coreClock,
   output logic periphClock,
   output logic flashClock,
   output logic converterClock,
   output logic asyncTimerClock,
   output cssc_domain_en_t domainEn,
   output logic coreHold,
   output cssc_source_t clockSource,
   output logic [2:0] oscRangeMode,
   output logic amplifierFullSwing,
   output logic startupBusy,
   output logic asyncIntDetect,
   output logic twiAddrMatch
);

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rstMeta_ff; // First reset stage
   logic rstSyncN; // Released reset used everywhere else

   // Assert at once, release after two edges
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_ff <= 1'h0;
         rstSyncN <= 1'h0;
      end else begin
         rstMeta_ff <= 1'h1;
         rstSyncN <= rstMeta_ff;
      end
   end

   // ****************************************************************
   // Fuse capture
   // ****************************************************************
   cssc_fuses_t fuse_ff; // Fuse image in use
   cssc_state_t state_ff; // Start-up sequencer state
   cssc_state_t nxt_state; // Next sequencer state

   // Fuses are a strap: loaded by a clocked process after release
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         fuse_ff.clockSourceSelectFuses <= `CSSC_CLOCK_SOURCE_SELECT_FUSES_RESET;
         fuse_ff.startupTimeFuses <= `CSSC_SUT_RESET;
         fuse_ff.amplifierSwingOption <= `CSSC_AMP_RESET;
      end else if (state_ff == ST_LOAD) begin
         fuse_ff <= fuseIn;
      end
   end

   // ****************************************************************
   // Fuse decoding
   // ****************************************************************
   function automatic cssc_source_t decodeSource(input logic [3:0] sel);
      cssc_source_t src;
      src = SRC_EXT_CLOCK;
      // Ranges tested from the top down
      if (sel >= `CSSC_CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN) begin
         src = SRC_XTAL;
      end else if (sel == `CSSC_CLOCK_SOURCE_SELECT_FUSES_LFXTAL) begin
         src = SRC_LF_XTAL;
      end else if (sel >= `CSSC_CLOCK_SOURCE_SELECT_FUSES_EXTRC_MIN) begin
         src = SRC_EXT_RC;
      end else if (sel >= `CSSC_CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN) begin
         src = SRC_INT_RC;
      end else begin
         src = SRC_EXT_CLOCK;
      end
      return src;
   endfunction

   function automatic cssc_startup_t decodeStartup(input cssc_source_t src, input logic selLow,
                                                    input logic [1:0] startup_time_fuses);
      cssc_startup_t su;
      su.ckCycles = `CSSC_CK_6;
      su.resetDelay = RD_LONG;
      case (src)
         SRC_XTAL: begin
            // Low select bit plus start-up fuses pick one of eight rows
            case ({selLow, startup_time_fuses})
               3'h0: su = '{`CSSC_CK_258, RD_SHORT};
               3'h1: su = '{`CSSC_CK_258, RD_LONG};
               3'h2: su = '{`CSSC_CK_1K, RD_NONE};
               3'h3: su = '{`CSSC_CK_1K, RD_SHORT};
               3'h4: su = '{`CSSC_CK_1K, RD_LONG};
               3'h5: su = '{CK_16K_CYCLES, RD_NONE};
               3'h6: su = '{CK_16K_CYCLES, RD_SHORT};
               default: su = '{CK_16K_CYCLES, RD_LONG};
            endcase
         end
         SRC_LF_XTAL: begin
            // Reserved code falls back to the slowest safe setting
            case (startup_time_fuses)
               2'h0: su = '{`CSSC_CK_1K, RD_SHORT};
               2'h1: su = '{`CSSC_CK_1K, RD_LONG};
               default: su = '{CK_32K_CYCLES, RD_LONG};
            endcase
         end
         SRC_EXT_RC: begin
            case (startup_time_fuses)
               2'h0: su = '{`CSSC_CK_18, RD_NONE};
               2'h1: su = '{`CSSC_CK_18, RD_SHORT};
               2'h2: su = '{`CSSC_CK_18, RD_LONG};
               default: su = '{`CSSC_CK_6, RD_SHORT};
            endcase
         end
         default: begin
            // Internal RC and external clock share the short count
            case (startup_time_fuses)
               2'h0: su = '{`CSSC_CK_6, RD_NONE};
               2'h1: su = '{`CSSC_CK_6, RD_SHORT};
               default: su = '{`CSSC_CK_6, RD_LONG};
            endcase
         end
      endcase
      return su;
   endfunction

   cssc_startup_t startup; // Decoded start-up setting
   logic [16:0] wdTarget; // Reset delay length in watchdog cycles

   // Source and start-up setting from the captured fuses
   always_comb begin
      startup = decodeStartup(decodeSource(fuse_ff.clockSourceSelectFuses),
                              fuse_ff.clockSourceSelectFuses[0], fuse_ff.startupTimeFuses);
      wdTarget = (startup.resetDelay == RD_LONG) ? WD_LONG_CYCLES : `CSSC_WD_SHORT;
   end

   // Registered source and oscillator mode outputs
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         clockSource <= SRC_INT_RC;
         oscRangeMode <= 3'h0;
         amplifierFullSwing <= 1'h0;
      end else begin
         clockSource <= decodeSource(fuse_ff.clockSourceSelectFuses);
         // Mode only meaningful for the crystal; a zero fuse bit is programmed
         if (decodeSource(fuse_ff.clockSourceSelectFuses) == SRC_XTAL) begin
            oscRangeMode <= fuse_ff.clockSourceSelectFuses[3:1];
            amplifierFullSwing <= ~fuse_ff.amplifierSwingOption;
         end else begin
            oscRangeMode <= 3'h0;
            amplifierFullSwing <= 1'h0;
         end
      end
   end

   // ****************************************************************
   // Watchdog oscillator sampling
   // ****************************************************************
   logic wdRise; // One pulse per watchdog oscillator cycle

   cssc_pin_sync u_wd_sync (
      .clock(clock),
      .rstN(rstSyncN),
      .pinIn(watchdogOscPin),
      .level(),
      .rise(wdRise)
   );

   // ****************************************************************
   // Start-up sequencer
   // ****************************************************************
   logic [16:0] wdCount_ff; // Watchdog cycles seen in the reset delay
   logic [16:0] ckCount_ff; // Source clock cycles seen in start-up
   logic wdDone; // Reset delay finished
   logic ckDone; // Clock start-up finished

   assign wdDone = (startup.resetDelay == RD_NONE) ||
                   (wdRise && (wdCount_ff == wdTarget - 17'h00001));
   assign ckDone = (ckCount_ff == startup.ckCycles - 17'h00001);

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_LOAD: nxt_state = ST_RESET_DELAY;
         ST_RESET_DELAY: begin
            // Extra reset delay comes first, then the oscillator count
            if (wdDone) begin
               nxt_state = ST_CLOCK_START;
            end
         end
         ST_CLOCK_START: begin
            if (ckDone) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (deepSleepReq) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // Wake from power-down restarts the oscillator count only
            if (wakeEvent) begin
               nxt_state = ST_CLOCK_START;
            end
         end
         default: nxt_state = ST_LOAD;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_ff <= ST_LOAD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Watchdog cycle counter, counts only on oscillator edges
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         wdCount_ff <= 17'h00000;
      end else if (state_ff != ST_RESET_DELAY) begin
         wdCount_ff <= 17'h00000;
      end else if (wdRise) begin
         wdCount_ff <= wdCount_ff + 17'h00001;
      end
   end

   // Source clock cycle counter
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ckCount_ff <= 17'h00000;
      end else if (state_ff != ST_CLOCK_START) begin
         ckCount_ff <= 17'h00000;
      end else begin
         ckCount_ff <= ckCount_ff + 17'h00001;
      end
   end

   // ****************************************************************
   // Domain enables and clock gates
   // ****************************************************************
   // Enables are registered so requests never glitch the gates
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         domainEn <= '0;
         coreHold <= 1'h1;
         startupBusy <= 1'h1;
      end else begin
         domainEn.core <= (nxt_state == ST_RUN) && !gateReq.core;
         domainEn.flash <= (nxt_state == ST_RUN) && !gateReq.core;
         domainEn.periph <= (nxt_state == ST_RUN) && !gateReq.periph;
         domainEn.adc <= (nxt_state == ST_RUN) && !gateReq.adc;
         coreHold <= !((nxt_state == ST_RUN) && !gateReq.core);
         startupBusy <= (nxt_state != ST_RUN) && (nxt_state != ST_SLEEP);
      end
   end

   // Core domain; its stopped clock freezes registers, flags and stack
   cssc_clock_gate u_core_gate (
      .clock(clock),
      .rstN(rstSyncN),
      .enable(domainEn.core),
      .gatedClock(coreClock)
   );

   // Flash domain follows the core enable
   cssc_clock_gate u_flash_gate (
      .clock(clock),
      .rstN(rstSyncN),
      .enable(domainEn.flash),
      .gatedClock(flashClock)
   );

   // Peripheral domain for timers, serial ports and interrupt logic
   cssc_clock_gate u_periph_gate (
      .clock(clock),
      .rstN(rstSyncN),
      .enable(domainEn.periph),
      .gatedClock(periphClock)
   );

   // Converter domain, independent of core and peripheral stops
   cssc_clock_gate u_adc_gate (
      .clock(clock),
      .rstN(rstSyncN),
      .enable(domainEn.adc),
      .gatedClock(converterClock)
   );

   // ****************************************************************
   // Unclocked paths
   // ****************************************************************
   // Crystal is passed on ungated so the counter keeps time in sleep
   assign asyncTimerClock = asyncCrystalClock;
   // Pure gates: work with every clock stopped, but carry no filtering
   assign asyncIntDetect = extIntPin;
   assign twiAddrMatch = twiAddrValid && (twiRxAddr == twiOwnAddr);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!rstSyncN);

   a_flash_with_core: assert property (domainEn.flash == domainEn.core)
      else $error("flash domain enable differs from core");
   // Hold is registered from the next state, so it is set in every cycle the current state is not run
   a_hold_not_run: assert property (state_ff != ST_RUN |-> coreHold)
      else $error("core released outside run state");
   a_wake_count: assert property ($past(state_ff) == ST_CLOCK_START && state_ff == ST_RUN
                                   |-> $past(ckCount_ff) == startup.ckCycles - 17'h00001)
      else $error("run entered before start-up count completed");
   a_reset_delay: assert property (state_ff == ST_RESET_DELAY && nxt_state == ST_CLOCK_START
                                    |-> startup.resetDelay == RD_NONE
                                        || wdCount_ff == wdTarget - 17'h00001)
      else $error("reset delay ended at the wrong watchdog count");
   a_sleep_to_start: assert property (state_ff == ST_SLEEP && wakeEvent |=> state_ff == ST_CLOCK_START)
      else $error("wake did not restart the clock count");
   a_xtal_decode: assert property (fuse_ff.clockSourceSelectFuses >= 4'ha |=> clockSource == SRC_XTAL)
      else $error("crystal codes not decoded as crystal");
   a_shipped_fuses: assert property (state_ff == ST_LOAD
                                     |-> fuse_ff == {`CSSC_CLOCK_SOURCE_SELECT_FUSES_RESET, `CSSC_SUT_RESET, `CSSC_AMP_RESET})
      else $error("fuse image not at shipped value after reset");
   a_amp_swing: assert property (clockSource == SRC_XTAL && $stable(fuse_ff)
                                  |-> amplifierFullSwing == !fuse_ff.amplifierSwingOption)
      else $error("amplifier swing not taken from programmed fuse");
   a_xtal_16k: assert property (decodeSource(fuse_ff.clockSourceSelectFuses) == SRC_XTAL
                                 && fuse_ff.clockSourceSelectFuses[0] && fuse_ff.startupTimeFuses == 2'h1
                                 |-> startup.ckCycles == CK_16K_CYCLES && startup.resetDelay == RD_NONE)
      else $error("crystal row 1/01 decoded wrongly");
   a_xtal_258: assert property (decodeSource(fuse_ff.clockSourceSelectFuses) == SRC_XTAL
                                 && !fuse_ff.clockSourceSelectFuses[0] && fuse_ff.startupTimeFuses == 2'h1
                                 |-> startup.ckCycles == `CSSC_CK_258 && startup.resetDelay == RD_LONG)
      else $error("crystal row 0/01 decoded wrongly");
   a_adc_alone: assert property (state_ff == ST_RUN && nxt_state == ST_RUN && gateReq.core
                                  && gateReq.periph && !gateReq.adc |=> domainEn.adc && !domainEn.core)
      else $error("converter domain not kept alone");

   c_reach_run: cover property (state_ff == ST_CLOCK_START ##1 state_ff == ST_RUN);
   c_wake_up: cover property (state_ff == ST_SLEEP ##1 state_ff == ST_CLOCK_START);
   c_reset_delay: cover property (state_ff == ST_RESET_DELAY && wdRise);
   c_adc_only: cover property (domainEn.adc && !domainEn.core);

endmodule

`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts every compare and reports a mismatch at once
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
   import cssc_pkg::*;
   // ****************************************************************
   // Stimulus and observation
   // ****************************************************************
   typedef struct {logic [6:0] fz; cssc_source_t src; logic [2:0] rng; logic amp; int ck; int wd;} cssc_row_t;
   logic clock = 1'b0, reset_n = 1'b0, wdPin = 1'b0, xtal = 1'b0, extIntPin = 1'b0;
   logic deepSleepReq = 1'b0, wakeEvent = 1'b0, twiAddrValid = 1'b0;
   logic [6:0] twiRxAddr = 7'h00, twiOwnAddr = 7'h2a;
   cssc_fuses_t fuseIn = 7'h45;
   cssc_gate_req_t gateReq = 3'h0;
   logic coreClock, periphClock, flashClock, converterClock, asyncTimerClock;
   logic coreHold, amplifierFullSwing, startupBusy, asyncIntDetect, twiAddrMatch;
   logic [2:0] oscRangeMode;
   cssc_domain_en_t domainEn;
   cssc_source_t clockSource;
   int fail_count = 0, checked = 0, cycles = 0, n = 0, coreRise = 0, adcRise = 0, c0 = 0, a0 = 0;
   int periphRise = 0, flashRise = 0, p0 = 0, f0 = 0;
   // Small counts keep the run short; expectations use the same values
   localparam int K16 = 64, K32 = 96, WDL = 40;
   cssc_row_t rows[10] = '{
      '{{4'ha, 2'h2, 1'b0}, SRC_XTAL, 3'h5, 1'b1, 1024, 0},
      '{{4'hf, 2'h1, 1'b1}, SRC_XTAL, 3'h7, 1'b0, K16, 0},
      '{{4'hd, 2'h3, 1'b1}, SRC_XTAL, 3'h6, 1'b0, K16, WDL},
      '{{4'hb, 2'h1, 1'b0}, SRC_XTAL, 3'h5, 1'b1, K16, 0},
      '{{4'h9, 2'h0, 1'b1}, SRC_LF_XTAL, 3'h0, 1'b0, 1024, 4096},
      '{{4'h7, 2'h0, 1'b0}, SRC_EXT_RC, 3'h0, 1'b0, 18, 0},
      '{{4'h0, 2'h0, 1'b1}, SRC_EXT_CLOCK, 3'h0, 1'b0, 6, 0},
      '{{4'h1, 2'h2, 1'b1}, SRC_INT_RC, 3'h0, 1'b0, 6, WDL},
      '{{4'hc, 2'h1, 1'b1}, SRC_XTAL, 3'h6, 1'b0, 258, WDL},
      '{{4'h9, 2'h2, 1'b1}, SRC_LF_XTAL, 3'h0, 1'b0, K32, WDL}
   };

   clock_source_startup_control #(.CK_16K_CYCLES(17'(K16)), .CK_32K_CYCLES(17'(K32)),
      .WD_LONG_CYCLES(17'(WDL))) clock_source_startup_control_i (
      .clock(clock), .reset_n(reset_n), .fuseIn(fuseIn), .watchdogOscPin(wdPin),
      .asyncCrystalClock(xtal), .gateReq(gateReq), .deepSleepReq(deepSleepReq),
      .wakeEvent(wakeEvent), .extIntPin(extIntPin), .twiRxAddr(twiRxAddr),
      .twiOwnAddr(twiOwnAddr), .twiAddrValid(twiAddrValid), .coreClock(coreClock),
      .periphClock(periphClock), .flashClock(flashClock), .converterClock(converterClock),
      .asyncTimerClock(asyncTimerClock), .domainEn(domainEn), .coreHold(coreHold),
      .clockSource(clockSource), .oscRangeMode(oscRangeMode),
      .amplifierFullSwing(amplifierFullSwing), .startupBusy(startupBusy),
      .asyncIntDetect(asyncIntDetect), .twiAddrMatch(twiAddrMatch));

   // ****************************************************************
   // Clocks: 20 MHz system, watchdog at a quarter of it, 32 kHz crystal
   // ****************************************************************
   always #25 clock = ~clock;
   always #100 wdPin = ~wdPin;
   always #15259 xtal = ~xtal;
   always @(posedge coreClock) coreRise++;
   always @(posedge converterClock) adcRise++;
   always @(posedge periphClock) periphRise++;
   always @(posedge flashClock) flashRise++;
   // Hang guard, well above the longest start-up
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         results();
      end
   end

   task automatic results();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Reset for five cycles with new fuses, then count until the core runs
   task automatic startUp(input logic [6:0] f);
      @(negedge clock);
      reset_n = 1'b0;
      fuseIn = f;
      gateReq = 3'h0;
      repeat (5) @(negedge clock);
      reset_n = 1'b1;
      n = 0;
      while (startupBusy !== 1'b0 && n < 20000) begin
         @(negedge clock);
         n++;
      end
   endtask

   // Deep sleep then wake; n counts the cycles spent busy
   task automatic sleepWake();
      deepSleepReq = 1'b1;
      @(negedge clock);
      deepSleepReq = 1'b0;
      repeat (3) @(negedge clock);
      `CHK(domainEn, 4'h0)
      `CHK(asyncTimerClock, xtal)
      wakeEvent = 1'b1;
      n = 0;
      for (int i = 0; i < 2000; i++) begin
         @(negedge clock);
         wakeEvent = 1'b0;
         if (startupBusy === 1'b1) n++;
         else if (n > 0) break;
      end
   endtask

   initial begin
      // ****************************************************************
      // Table of fuse settings
      // ****************************************************************
      foreach (rows[i]) begin
         startUp(rows[i].fz);
         `CHK((n >= rows[i].ck + 4 * rows[i].wd) && (n <= rows[i].ck + 4 * rows[i].wd + 16), 1'b1)
         `CHK(clockSource, rows[i].src)
         `CHK(oscRangeMode, rows[i].rng)
         `CHK(amplifierFullSwing, rows[i].amp)
         `CHK(domainEn, 4'hf)
         sleepWake();
         `CHK(n, rows[i].ck)
      end
      // ****************************************************************
      // Domain gating and clockless detection, left in run state
      // ****************************************************************
      gateReq = 3'h4;
      repeat (2) @(negedge clock);
      `CHK(domainEn, 4'h5)
      `CHK(coreHold, 1'b1)
      c0 = coreRise;
      a0 = adcRise;
      p0 = periphRise;
      f0 = flashRise;
      repeat (4) @(negedge clock);
      `CHK(coreRise, c0)
      `CHK(adcRise, a0 + 4)
      `CHK(periphRise, p0 + 4)
      `CHK(flashRise, f0)
      gateReq = 3'h6;
      repeat (2) @(negedge clock);
      `CHK(domainEn, 4'h1)
      extIntPin = 1'b1;
      twiRxAddr = 7'h2a;
      twiAddrValid = 1'b1;
      #5 `CHK(asyncIntDetect, 1'b1)
      `CHK(twiAddrMatch, 1'b1)
      twiRxAddr = 7'h2b;
      #5 `CHK(twiAddrMatch, 1'b0)
      extIntPin = 1'b0;
      #5 `CHK(asyncIntDetect, 1'b0)
      @(negedge clock);
      gateReq = 3'h0;
      wakeEvent = 1'b1;
      repeat (3) @(negedge clock);
      `CHK(startupBusy, 1'b0)
      `CHK(domainEn, 4'hf)
      `CHK(coreHold, 1'b0)
      results();
   end
endmodule
`default_nettype wire
